// ---- design/hub_reset_consts.vh ----
/*
 * Constants for the hub reset and bus recovery block: timing counts,
 * field widths, reset values and the device type prefix.
 * Assumes a 40 MHz system clock; times are given in nanoseconds.
 */
`ifndef HUB_RESET_CONSTS_VH
`define HUB_RESET_CONSTS_VH

// System clock period in ns
`define CLK_PERIOD_NS 25
// Address sense delay after supply valid, ns (longest time: round down)
`define ADDR_SENSE_NS 5000
`define ADDR_SENSE_CYC (`ADDR_SENSE_NS / `CLK_PERIOD_NS)
// Initialization delay after power-up, ns (longest time: round down)
`define INIT_DELAY_NS 10000
`define INIT_DELAY_CYC (`INIT_DELAY_NS / `CLK_PERIOD_NS)
// Host clock low timeout, minimum and maximum, ns
`define TIMEOUT_MIN_NS 10000000
`define TIMEOUT_MAX_NS 50000000
// Default trip point sits midway between min and max, rounded up to whole cycles
`define TIMEOUT_DEF_NS 30000000
`define TIMEOUT_DEF_CYC ((`TIMEOUT_DEF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Bus clear clock pulse count
`define BUS_CLEAR_PULSES 18
// Device type prefix of the 7-bit bus address
`define DEV_TYPE_PREFIX 4'ha
// Cleared field widths and reset values
`define IFACE_CFG_FIELD_W 3
`define IFACE_CFG_FIELD_RST 3'h0
`define ERR_STAT_FIELD_RST 2'h0
// Sense code for a pin tied directly to ground
`define SENSE_GND_CODE 4'h8

`endif

// ---- design/hub_bus_recovery.v ----
/*
 * Power-up sequencing, address-pin sensing, bus clear and bus-reset
 * timeout for the memory hub. Assumes the address pin's resistance is
 * converted outside into a 4-bit code (0..7 = resistor index ascending,
 * 8 = tied to ground) with a valid strobe; host bus pins arrive
 * asynchronously and are synchronised here.
 */
`timescale 1ns/100ps
`include "hub_reset_consts.vh"

module hub_bus_recovery #(
    parameter [31:0] TIMEOUT_CYC = `TIMEOUT_DEF_CYC
) (
    input wire clk_sys,
    input wire rst,
    input wire supply_valid,
    input wire [3:0] addr_sense_code,
    input wire addr_sense_valid,
    input wire host_bus_clock,
    input wire host_bus_data_in,
    input wire i3c_mode_set,
    input wire proto_drive_low,
    output reg host_bus_data_out,
    output reg host_bus_data_oe,
    output reg local_bus_data_out,
    output reg local_bus_data_oe,
    output reg [2:0] host_id_code,
    output reg offline_mode,
    output reg [6:0] bus_address,
    output reg iface_enable,
    output reg i3c_mode,
    output reg push_pull_mode,
    output reg bus_reset_pulse,
    output reg stop_event,
    output reg clear_iface_cfg_field,
    output reg clear_int_cfg_bit,
    output reg clear_err_stat_field,
    output reg bus_clear_done
);

    // ****************************************************
    // Power-up sequencer
    // ****************************************************
    localparam ST_WAIT_SUPPLY = 2'h0;
    localparam ST_SENSE = 2'h1;
    localparam ST_INIT = 2'h2;
    localparam ST_READY = 2'h3;
    localparam [15:0] SENSE_CYC = `ADDR_SENSE_CYC;
    localparam [15:0] INIT_CYC = `INIT_DELAY_CYC;
    localparam [4:0] CLEAR_PULSES = `BUS_CLEAR_PULSES;

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [15:0] seq_cnt_reg;
    reg supply_s1_reg, supply_s2_reg;
    reg scl_s1_reg, scl_s2_reg, scl_d_reg;
    reg sda_s1_reg, sda_s2_reg, sda_d_reg;
    reg sv_s1_reg, sv_s2_reg;
    reg [3:0] code_s1_reg, code_s2_reg;
    reg [31:0] low_cnt_reg;
    reg [4:0] pulse_cnt_reg;
    reg hung_reg;

    wire scl_fall = ~scl_s2_reg & scl_d_reg;
    // Start and stop need the clock settled high for a sample, so a data
    // change landing beside a clock edge is not taken for either
    wire stop_seen = scl_s2_reg & scl_d_reg & sda_s2_reg & ~sda_d_reg;
    wire start_seen = scl_s2_reg & scl_d_reg & ~sda_s2_reg & sda_d_reg;
    wire timeout_hit = (low_cnt_reg >= TIMEOUT_CYC);

    // Two-flop synchronisers for every pin-side input
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            supply_s1_reg <= 1'b0;
            supply_s2_reg <= 1'b0;
            scl_s1_reg <= 1'b1;
            scl_s2_reg <= 1'b1;
            scl_d_reg <= 1'b1;
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            sv_s1_reg <= 1'b0;
            sv_s2_reg <= 1'b0;
            code_s1_reg <= 4'h0;
            code_s2_reg <= 4'h0;
        end else begin
            supply_s1_reg <= supply_valid;
            supply_s2_reg <= supply_s1_reg;
            scl_s1_reg <= host_bus_clock;
            scl_s2_reg <= scl_s1_reg;
            scl_d_reg <= scl_s2_reg;
            sda_s1_reg <= host_bus_data_in;
            sda_s2_reg <= sda_s1_reg;
            sda_d_reg <= sda_s2_reg;
            sv_s1_reg <= addr_sense_valid;
            sv_s2_reg <= sv_s1_reg;
            code_s1_reg <= addr_sense_code;
            code_s2_reg <= code_s1_reg;
        end
    end

    // Next-state logic; sensing falls through on timer expiry so a dead
    // converter cannot stall start-up, defaulting to host ID 000
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_WAIT_SUPPLY: begin
                if (supply_s2_reg) begin
                    state_next = ST_SENSE;
                end
            end
            ST_SENSE: begin
                if (sv_s2_reg || seq_cnt_reg >= SENSE_CYC - 16'h0001) begin
                    state_next = ST_INIT;
                end
            end
            ST_INIT: begin
                if (seq_cnt_reg >= INIT_CYC - 16'h0001) begin
                    state_next = ST_READY;
                end
            end
            default: state_next = ST_READY;
        endcase
    end

    // Sequencer state, sense latch and address; the sense path is taken
    // once only, so a bus reset never revisits it
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg <= ST_WAIT_SUPPLY;
            seq_cnt_reg <= 16'h0000;
            host_id_code <= 3'h0;
            offline_mode <= 1'b0;
            bus_address <= {`DEV_TYPE_PREFIX, 3'h0};
            iface_enable <= 1'b0;
        end else begin
            state_reg <= state_next;
            seq_cnt_reg <= (state_next != state_reg) ? 16'h0000 : seq_cnt_reg + 16'h0001;
            if (state_reg == ST_SENSE && state_next == ST_INIT) begin
                if (sv_s2_reg && code_s2_reg == `SENSE_GND_CODE) begin
                    host_id_code <= 3'h0;
                    offline_mode <= 1'b1;
                    bus_address <= {`DEV_TYPE_PREFIX, 3'h0};
                end else if (sv_s2_reg && !code_s2_reg[3]) begin
                    host_id_code <= code_s2_reg[2:0];
                    bus_address <= {`DEV_TYPE_PREFIX, code_s2_reg[2:0]};
                end
            end
            iface_enable <= (state_next == ST_READY);
        end
    end

    // ****************************************************
    // Bus reset timeout and bus clear
    // ****************************************************

    // Clock-low counter: restarts while the clock is high, saturates so a
    // permanently low clock yields a single reset; mode is not consulted
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            low_cnt_reg <= 32'h0000_0000;
        end else if (scl_s2_reg || !iface_enable) begin
            low_cnt_reg <= 32'h0000_0000;
        end else if (!timeout_hit) begin
            low_cnt_reg <= low_cnt_reg + 32'h0000_0001;
        end
    end

    // Mode, drivers and bus clear tracking
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            i3c_mode <= 1'b0;
            push_pull_mode <= 1'b0;
            host_bus_data_out <= 1'b0;
            host_bus_data_oe <= 1'b0;
            local_bus_data_out <= 1'b1;
            local_bus_data_oe <= 1'b0;
            bus_reset_pulse <= 1'b0;
            stop_event <= 1'b0;
            clear_iface_cfg_field <= 1'b0;
            clear_int_cfg_bit <= 1'b0;
            clear_err_stat_field <= 1'b0;
            bus_clear_done <= 1'b0;
            pulse_cnt_reg <= 5'h00;
            hung_reg <= 1'b0;
        end else begin
            bus_reset_pulse <= 1'b0;
            stop_event <= 1'b0;
            clear_iface_cfg_field <= 1'b0;
            clear_int_cfg_bit <= 1'b0;
            clear_err_stat_field <= 1'b0;
            bus_clear_done <= 1'b0;
            local_bus_data_out <= 1'b1;
            local_bus_data_oe <= 1'b0;
            if (low_cnt_reg == TIMEOUT_CYC - 32'h0000_0001) begin
                bus_reset_pulse <= 1'b1;
                stop_event <= 1'b1;
                i3c_mode <= 1'b0;
                push_pull_mode <= 1'b0;
                clear_iface_cfg_field <= 1'b1;
                clear_int_cfg_bit <= 1'b1;
                clear_err_stat_field <= 1'b1;
                host_bus_data_oe <= 1'b0;
                local_bus_data_oe <= 1'b1;
                pulse_cnt_reg <= 5'h00;
                hung_reg <= 1'b0;
            end else begin
                if (i3c_mode_set && iface_enable) begin
                    i3c_mode <= 1'b1;
                    push_pull_mode <= 1'b1;
                end
                // Drive low only when the protocol asks and no clear forced release
                host_bus_data_oe <= proto_drive_low & iface_enable & ~hung_reg;
                if (stop_seen || start_seen) begin
                    stop_event <= stop_seen;
                    pulse_cnt_reg <= 5'h00;
                    if (hung_reg) begin
                        bus_clear_done <= stop_seen;
                    end
                    hung_reg <= 1'b0;
                end else if (!i3c_mode && scl_fall && !hung_reg) begin
                    // Count falling clock edges: the release then lands in a low
                    // phase, so letting go of data never forms a STOP on the wire
                    if (pulse_cnt_reg >= CLEAR_PULSES - 5'h01) begin
                        hung_reg <= 1'b1;
                    end else begin
                        pulse_cnt_reg <= pulse_cnt_reg + 5'h01;
                    end
                end
            end
        end
    end

endmodule

// ---- testbench/hub_bus_recovery_assertions.sv ----
/* Checker of the bus reset, address and start-up outputs of hub_bus_recovery.
   Bound to the design and sees only its ports. */
`timescale 1ns/100ps
module hub_bus_recovery_chk #(
    parameter [31:0] TIMEOUT_CYC = 32'd64
) (
    input wire clk_sys,
    input wire rst,
    input wire host_bus_clock,
    input wire host_bus_data_oe,
    input wire local_bus_data_out,
    input wire local_bus_data_oe,
    input wire [2:0] host_id_code,
    input wire offline_mode,
    input wire [6:0] bus_address,
    input wire iface_enable,
    input wire i3c_mode,
    input wire push_pull_mode,
    input wire bus_reset_pulse,
    input wire stop_event,
    input wire clear_iface_cfg_field,
    input wire clear_int_cfg_bit,
    input wire clear_err_stat_field,
    input wire bus_clear_done
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    reg [31:0] low_reg;
    reg seen_reg;
    // Raw clock-low span; the design's synced view can only be shorter
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            low_reg <= 32'h0;
            seen_reg <= 1'b0;
        end else begin
            low_reg <= host_bus_clock ? 32'h0 : low_reg + 32'h1;
            seen_reg <= !host_bus_clock && (seen_reg || bus_reset_pulse);
        end
    end
    sequence reset_acts;
        !host_bus_data_oe && !i3c_mode && stop_event && local_bus_data_oe
            && local_bus_data_out;
    endsequence
    addr_join_a: assert property (bus_address == {4'ha, host_id_code})
        else $error("bus address mismatch");
    reset_acts_a: assert property (bus_reset_pulse |-> reset_acts)
        else $error("bus reset effects missing");
    reset_clears_a: assert property (bus_reset_pulse |-> clear_iface_cfg_field
        && clear_int_cfg_bit && clear_err_stat_field) else $error("field clears missing");
    reset_early_a: assert property (bus_reset_pulse |-> low_reg >= TIMEOUT_CYC)
        else $error("bus reset before timeout");
    reset_due_a: assert property (iface_enable && low_reg == TIMEOUT_CYC + 8 |-> seen_reg)
        else $error("no bus reset after timeout");
    reset_once_a: assert property (bus_reset_pulse |=> !bus_reset_pulse)
        else $error("repeated bus reset");
    id_hold_a: assert property (iface_enable |=> $stable(host_id_code)
        && $stable(offline_mode)) else $error("host id changed");
    offline_id_a: assert property (offline_mode |-> host_id_code == 3'h0)
        else $error("offline id not zero");
    start_mode_a: assert property ($rose(iface_enable) |-> !i3c_mode && !push_pull_mode)
        else $error("not in open-drain mode at start");
    clear_done_a: assert property (bus_clear_done |-> stop_event && !host_bus_data_oe)
        else $error("bus clear end without released stop");
endmodule
bind hub_bus_recovery hub_bus_recovery_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk_i (
    .clk_sys(clk_sys),
    .rst(rst),
    .host_bus_clock(host_bus_clock),
    .host_bus_data_oe(host_bus_data_oe),
    .local_bus_data_out(local_bus_data_out),
    .local_bus_data_oe(local_bus_data_oe),
    .host_id_code(host_id_code),
    .offline_mode(offline_mode),
    .bus_address(bus_address),
    .iface_enable(iface_enable),
    .i3c_mode(i3c_mode),
    .push_pull_mode(push_pull_mode),
    .bus_reset_pulse(bus_reset_pulse),
    .stop_event(stop_event),
    .clear_iface_cfg_field(clear_iface_cfg_field),
    .clear_int_cfg_bit(clear_int_cfg_bit),
    .clear_err_stat_field(clear_err_stat_field),
    .bus_clear_done(bus_clear_done)
);

// ---- testbench/host_ctrl_model.sv ----
/* Host controller model: drives the host clock and pulls host data low.
   Assumes the bench resolves the data wire with a pull-up. */
`timescale 1ns/100ps
module host_ctrl_model (
    output reg host_bus_clock,
    output reg host_pull_low
);
    // Clock stands high between frames, data released
    initial begin
        host_bus_clock = 1'b1;
        host_pull_low = 1'b0;
    end
    // Bus clear pulses at 200 ns with data left undriven
    task pulses(input integer k);
        integer i;
        begin
            host_pull_low = 1'b0;
            for (i = 0; i < k; i = i + 1) begin
                #100 host_bus_clock = 1'b0;
                #100 host_bus_clock = 1'b1;
            end
        end
    endtask
    // STOP: data rises while the clock is high
    task stop;
        begin
            #100 host_bus_clock = 1'b0;
            host_pull_low = 1'b1;
            #100 host_bus_clock = 1'b1;
            #100 host_pull_low = 1'b0;
        end
    endtask
    // Long low forces a bus reset, short low must not
    task hold_low(input integer ns);
        begin
            host_bus_clock = 1'b0;
            #(ns) host_bus_clock = 1'b1;
        end
    endtask
endmodule

// ---- testbench/test_hub_bus_recovery.sv ----
/* Self-checking bench for hub_bus_recovery.
   Assumes host_ctrl_model and the bound checker are compiled alongside. */
`timescale 1ns/100ps
module test_hub_bus_recovery;
    reg clk_sys = 1'b0;
    reg rst = 1'b1;
    reg supply_valid = 1'b0;
    reg [3:0] addr_sense_code = 4'h0;
    reg addr_sense_valid = 1'b0;
    reg i3c_mode_set = 1'b0;
    reg proto_drive_low = 1'b0;
    wire host_bus_data_out, host_bus_data_oe, local_bus_data_out, local_bus_data_oe;
    wire offline_mode, iface_enable, i3c_mode, push_pull_mode, bus_reset_pulse;
    wire stop_event, bus_clear_done, clear_iface_cfg_field, clear_int_cfg_bit;
    wire clear_err_stat_field, host_bus_clock, host_pull_low;
    wire [2:0] host_id_code;
    wire [6:0] bus_address;
    // Open-drain data line with pull-up
    wire host_bus_data_in = !(host_bus_data_oe || host_pull_low);
    integer err_count = 0, checks = 0, n, c, e, rst_seen = 0, done_seen = 0;
    hub_bus_recovery #(.TIMEOUT_CYC(32'd64)) uut (
        .clk_sys(clk_sys),
        .rst(rst),
        .supply_valid(supply_valid),
        .addr_sense_code(addr_sense_code),
        .addr_sense_valid(addr_sense_valid),
        .host_bus_clock(host_bus_clock),
        .host_bus_data_in(host_bus_data_in),
        .i3c_mode_set(i3c_mode_set),
        .proto_drive_low(proto_drive_low),
        .host_bus_data_out(host_bus_data_out),
        .host_bus_data_oe(host_bus_data_oe),
        .local_bus_data_out(local_bus_data_out),
        .local_bus_data_oe(local_bus_data_oe),
        .host_id_code(host_id_code),
        .offline_mode(offline_mode),
        .bus_address(bus_address),
        .iface_enable(iface_enable),
        .i3c_mode(i3c_mode),
        .push_pull_mode(push_pull_mode),
        .bus_reset_pulse(bus_reset_pulse),
        .stop_event(stop_event),
        .clear_iface_cfg_field(clear_iface_cfg_field),
        .clear_int_cfg_bit(clear_int_cfg_bit),
        .clear_err_stat_field(clear_err_stat_field),
        .bus_clear_done(bus_clear_done)
    );
    host_ctrl_model host (.host_bus_clock(host_bus_clock), .host_pull_low(host_pull_low));
    always #12.5 clk_sys = ~clk_sys;
    // Count one-cycle pulses so none is missed between checks
    always @(posedge clk_sys) begin
        if (bus_reset_pulse === 1'b1) rst_seen <= rst_seen + 1;
        if (bus_clear_done === 1'b1) done_seen <= done_seen + 1;
    end
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("Error at %0t: got %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("Mismatches %0d, checks %0d", err_count, checks);
            if (err_count == 0 && checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    // Full power-up; the enable wait is bounded by sense plus init time
    task power_up(input [3:0] code);
        begin
            rst = 1'b1;
            supply_valid = 1'b0;
            addr_sense_valid = 1'b0;
            addr_sense_code = code;
            repeat (5) @(negedge clk_sys);
            rst = 1'b0;
            supply_valid = 1'b1;
            addr_sense_valid = 1'b1;
            n = 0;
            while (iface_enable !== 1'b1 && n < 2000) begin
                @(negedge clk_sys);
                n = n + 1;
            end
            chk(n >= 400 && n <= 620, 1);
        end
    endtask
    initial begin
        for (c = 0; c < 9; c = c + 1) begin
            power_up(c);
            e = (c == 8) ? 0 : c;
            chk(host_id_code, e);
            chk(offline_mode, c == 8);
            chk(bus_address, 32'h50 + e);
        end
        power_up(4'h5);
        proto_drive_low = 1'b1;
        // Data must really be held low before the clear can prove a release
        repeat (2) @(negedge clk_sys);
        chk(host_bus_data_oe, 1);
        host.pulses(18);
        repeat (5) @(negedge clk_sys);
        chk(host_bus_data_oe, 0);
        proto_drive_low = 1'b0;
        host.stop;
        repeat (5) @(negedge clk_sys);
        chk(done_seen, 1);
        host.hold_low(1500);
        repeat (5) @(negedge clk_sys);
        chk(rst_seen, 0);
        i3c_mode_set = 1'b1;
        @(negedge clk_sys);
        i3c_mode_set = 1'b0;
        proto_drive_low = 1'b1;
        host.pulses(18);
        repeat (5) @(negedge clk_sys);
        chk(i3c_mode, 1);
        chk(host_bus_data_oe, 1);
        host.hold_low(2500);
        proto_drive_low = 1'b0;
        repeat (5) @(negedge clk_sys);
        chk(rst_seen, 1);
        chk(i3c_mode, 0);
        chk(host_id_code, 5);
        chk(push_pull_mode, 0);
        chk(host_bus_data_out, 0);
        report_and_stop;
    end
    // Whole run is about 4600 cycles; cut a hang well beyond that
    initial begin
        #1000000;
        err_count = err_count + 1;
        report_and_stop;
    end
endmodule
